// [logic/dee_pkg.sv]
// Constants, types and state layout of the data store access controller
package dee_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL    = 12'hfa6;
    localparam logic [11:0] ADDR_KEY        = 12'hfa7;
    localparam logic [11:0] ADDR_BUFFER     = 12'hfa8;
    localparam logic [11:0] ADDR_INDEX_LOW  = 12'hfa9;
    localparam logic [11:0] ADDR_INDEX_HIGH = 12'hfaa;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int BIT_READ       = 0;
    localparam int BIT_WRITE      = 1;
    localparam int BIT_PERMIT     = 2;
    localparam int BIT_ABORT      = 3;
    localparam int BIT_ROW_ERASE  = 4;
    localparam int BIT_UNUSED     = 5;
    localparam int BIT_CFG_SEL    = 6;
    localparam int BIT_PROG_SEL   = 7;

    // ------------------------------------------------------------------
    // Sizes, reset values and keys
    // ------------------------------------------------------------------
    localparam int          DATA_W       = 8;
    localparam int          INDEX_W      = 10;
    localparam int          DEPTH        = 1024;
    localparam int          HIGH_W       = 2;
    localparam int          CNT_W        = 24;
    localparam int unsigned WRITE_CYCLES_DEFAULT = 20000;
    localparam logic [7:0]  INDEX_RST    = 8'h00;
    localparam logic [7:0]  BUFFER_RST   = 8'h00;
    localparam logic [7:0]  READ_ZERO    = 8'h00;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'haa;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_HALF  = 2'b01,
        KEY_ARMED = 2'b10
    } dee_key_t;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_ERASE   = 2'b01,
        PH_PROGRAM = 2'b10
    } dee_phase_t;

    typedef struct packed {
        logic [1:0]        syncA;
        logic [1:0]        syncB;
        logic              progSel;
        logic              cfgSel;
        logic              rowErase;
        logic              abortFlag;
        logic              permit;
        logic              wrBusy;
        logic              rdBusy;
        logic              rdCopy;
        logic [HIGH_W-1:0] idxHigh;
        logic [7:0]        idxLow;
        logic [7:0]        buffer;
        dee_key_t          key;
        dee_phase_t        phase;
        logic [CNT_W-1:0]  cnt;
        logic              doneFlag;
        logic [7:0]        rdData;
    } dee_state_t;

endpackage

// [logic/dee_mem.sv]
// Byte array of the data store with registered read data
`timescale 1ns/1ps
module dee_mem
    import dee_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               rdEn,
    input  wire logic [INDEX_W-1:0] rdAddr,
    output logic      [DATA_W-1:0]  rdData,
    input  wire logic               store_permit_bit,
    input  wire logic [INDEX_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0]  wrData
);

    logic [DATA_W-1:0] cells [DEPTH];

    // Array itself has no reset: contents are nonvolatile by intent
    always_ff @(posedge clk_sys)
    begin
        if (store_permit_bit)
        begin
            cells[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdData <= READ_ZERO;
        end
        else if (rdEn)
        begin
            rdData <= cells[rdAddr];
        end
    end

endmodule

// [logic/dee_ctrl.sv]
// Register-driven controller for the 1024-byte data store
//
// Function
// - 1024 byte locations, index 0 to 3FFh, one byte per access.
// - Index high holds top two bits, low holds eight; high upper six read zero.
// - Byte write erases then programs; an internal timer sets cycle length.
// - Unlock key port stores nothing and reads zero.
// - Software can only set read and write triggers; hardware clears them.
// - Store permit enables writes when set; cleared at power-up.
// - Reset pin or watchdog during a write sets store abort flag.
// - Abort leaves program select and row erase select unchanged.
// - Those resets clear byte buffer and both index registers.
// - Write completion sets store done flag; only software clears it.
// - Control bit 7 selects program array when one, data store when zero.
// - Control bit 6 selects configuration space when one.
// - Control bit 4 is a stored row erase select that the write does not use; clears on completion.
// - Control bit 1 starts timed write, reads one until it completes.
// - Control bit 0 starts one-cycle read; not settable with program select.
// - Control bit 5 is unimplemented and reads zero.
// - Read of loaded index is in the buffer for the next access.
// - Buffer holds read value until next read or software write.
// - Write starts only after 55h then AAh to key port, then trigger.
// - Write trigger refused unless permit already set beforehand.
// - During a write, control, index and buffer are not modifiable.
`timescale 1ns/1ps
module dee_ctrl
    import dee_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEFAULT
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        extResetPin,
    input  wire logic        watchdogReset,
    input  wire logic [11:0] regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    input  wire logic        storeDoneClr,
    output logic             storeDoneFlag,
    output logic             writeBusy
);

    // Erase takes one cycle of the budget, so the program phase counts the rest
    localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(WRITE_CYCLES - 2);

    dee_state_t             state_r;
    dee_state_t             state_nxt;
    logic                   memRdEn;
    logic [DATA_W-1:0]      memRdData;
    logic                   memWrEn;
    logic [DATA_W-1:0]      memWrData;
    logic [INDEX_W-1:0]     curIndex;
    logic                   warmReset;
    logic                   writing;
    logic                   dataTarget;
    logic [7:0]             readback;

    // ------------------------------------------------------------------
    // Byte array
    // ------------------------------------------------------------------
    assign curIndex = {state_r.idxHigh, state_r.idxLow};

    dee_mem u_mem
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .rdEn    (memRdEn),
        .rdAddr  (curIndex),
        .rdData  (memRdData),
        .store_permit_bit    (memWrEn),
        .wrAddr  (curIndex),
        .wrData  (memWrData)
    );

    // ------------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------------
    always_comb
    begin
        readback = READ_ZERO;
        unique case (regAddr)
            ADDR_CONTROL:
            begin
                readback[BIT_PROG_SEL]  = state_r.progSel;
                readback[BIT_CFG_SEL]   = state_r.cfgSel;
                readback[BIT_UNUSED]    = 1'b0;
                readback[BIT_ROW_ERASE] = state_r.rowErase;
                readback[BIT_ABORT]     = state_r.abortFlag;
                readback[BIT_PERMIT]    = state_r.permit;
                readback[BIT_WRITE]     = state_r.wrBusy;
                readback[BIT_READ]      = state_r.rdBusy;
            end
            ADDR_KEY:        readback = READ_ZERO;
            ADDR_BUFFER:     readback = state_r.buffer;
            ADDR_INDEX_LOW:  readback = state_r.idxLow;
            ADDR_INDEX_HIGH: readback = {6'h00, state_r.idxHigh};
            default:         readback = READ_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign warmReset  = |state_r.syncB;
    assign writing    = (state_r.phase != PH_IDLE);
    // Program flash and configuration space are not modelled here
    assign dataTarget = !state_r.progSel && !state_r.cfgSel;

    always_comb
    begin
        state_nxt = state_r;
        memRdEn   = 1'b0;
        memWrEn   = 1'b0;
        memWrData = state_r.buffer;

        state_nxt.syncA = {extResetPin, watchdogReset};
        state_nxt.syncB = state_r.syncA;

        // Read trigger lives exactly one cycle
        state_nxt.rdBusy = 1'b0;
        state_nxt.rdCopy = 1'b0;
        if (state_r.rdCopy)
        begin
            state_nxt.buffer = memRdData;
        end

        // Clear first so that a completion in the same cycle wins
        if (storeDoneClr)
        begin
            state_nxt.doneFlag = 1'b0;
        end

        if (regRdEn)
        begin
            state_nxt.rdData = readback;
        end

        // Timed erase-then-program cycle
        if (!warmReset)
        begin
            unique case (state_r.phase)
                PH_IDLE:
                begin
                    state_nxt.cnt = '0;
                end
                PH_ERASE:
                begin
                    memWrEn         = dataTarget;
                    memWrData       = ERASED_BYTE;
                    state_nxt.phase = PH_PROGRAM;
                    state_nxt.cnt   = '0;
                end
                PH_PROGRAM:
                begin
                    if (state_r.cnt == LAST_COUNT)
                    begin
                        memWrEn            = dataTarget;
                        memWrData          = state_r.buffer;
                        state_nxt.phase    = PH_IDLE;
                        state_nxt.wrBusy   = 1'b0;
                        state_nxt.rowErase = 1'b0;
                        state_nxt.abortFlag = 1'b0;
                        state_nxt.doneFlag = 1'b1;
                    end
                    else
                    begin
                        state_nxt.cnt = state_r.cnt + CNT_W'(1);
                    end
                end
                default:
                begin
                    state_nxt.phase  = PH_IDLE;
                    state_nxt.wrBusy = 1'b0;
                end
            endcase
        end

        // Register writes
        if (regWrEn && !warmReset)
        begin
            // Any write other than the next key step breaks the unlock
            state_nxt.key = KEY_IDLE;
            unique case (regAddr)
                ADDR_KEY:
                begin
                    if (state_r.key == KEY_IDLE && regWrData == KEY_FIRST)
                    begin
                        state_nxt.key = KEY_HALF;
                    end
                    else if (state_r.key == KEY_HALF && regWrData == KEY_SECOND)
                    begin
                        state_nxt.key = KEY_ARMED;
                    end
                end
                ADDR_CONTROL:
                begin
                    if (!writing)
                    begin
                        state_nxt.progSel   = regWrData[BIT_PROG_SEL];
                        state_nxt.cfgSel    = regWrData[BIT_CFG_SEL];
                        state_nxt.rowErase  = regWrData[BIT_ROW_ERASE];
                        state_nxt.abortFlag = regWrData[BIT_ABORT];
                        state_nxt.permit    = regWrData[BIT_PERMIT];
                        // Select taken from the same write so a combined write is safe
                        if (regWrData[BIT_READ] && !regWrData[BIT_PROG_SEL])
                        begin
                            state_nxt.rdBusy = 1'b1;
                            if (!regWrData[BIT_CFG_SEL])
                            begin
                                memRdEn          = 1'b1;
                                state_nxt.rdCopy = 1'b1;
                            end
                        end
                        // Permit must already stand before this write
                        if (regWrData[BIT_WRITE] && state_r.permit
                            && state_r.key == KEY_ARMED)
                        begin
                            state_nxt.wrBusy = 1'b1;
                            state_nxt.phase  = PH_ERASE;
                        end
                    end
                end
                ADDR_BUFFER:
                begin
                    if (!writing)
                    begin
                        state_nxt.buffer = regWrData;
                    end
                end
                ADDR_INDEX_LOW:
                begin
                    if (!writing)
                    begin
                        state_nxt.idxLow = regWrData;
                    end
                end
                ADDR_INDEX_HIGH:
                begin
                    if (!writing)
                    begin
                        state_nxt.idxHigh = regWrData[HIGH_W-1:0];
                    end
                end
                default:
                begin
                    state_nxt.key = KEY_IDLE;
                end
            endcase
        end

        // Warm reset from pin or watchdog overrides everything above
        if (warmReset)
        begin
            if (writing)
            begin
                state_nxt.abortFlag = 1'b1;
            end
            // Later warm cycles must not lose row erase once an abort was logged
            else if (!state_r.abortFlag)
            begin
                state_nxt.rowErase = 1'b0;
            end
            // progSel and cfgSel deliberately untouched for tracing
            state_nxt.phase   = PH_IDLE;
            state_nxt.cnt     = '0;
            state_nxt.wrBusy  = 1'b0;
            state_nxt.rdBusy  = 1'b0;
            state_nxt.rdCopy  = 1'b0;
            state_nxt.permit  = 1'b0;
            state_nxt.key     = KEY_IDLE;
            state_nxt.idxLow  = INDEX_RST;
            state_nxt.idxHigh = INDEX_RST[HIGH_W-1:0];
            state_nxt.buffer  = BUFFER_RST;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign regRdData     = state_r.rdData;
    assign storeDoneFlag = state_r.doneFlag;
    assign writeBusy     = state_r.wrBusy;

endmodule

// [test/dee_ctrl_asserts.sv]
// Port-level assertion checker for the data store access controller
`timescale 1ns/1ps
module dee_ctrl_asserts
    import dee_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 8
)
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        extResetPin,
    input wire logic        watchdogReset,
    input wire logic [11:0] regAddr,
    input wire logic        regWrEn,
    input wire logic [7:0]  regWrData,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    input wire logic        storeDoneClr,
    input wire logic        storeDoneFlag,
    input wire logic        writeBusy
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [31:0] busyRun_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busyRun_r <= 32'h0;
        else
            busyRun_r <= writeBusy ? busyRun_r + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence ctrlRead;
        regRdEn && regAddr == ADDR_CONTROL;
    endsequence

    sequence warmHit;
        (extResetPin || watchdogReset) && writeBusy;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    done_with_end_a: assert property (
        $rose(storeDoneFlag) |-> $fell(writeBusy)) else $error("done flag without write end");
    write_time_a: assert property (
        $rose(storeDoneFlag) |-> busyRun_r == WRITE_CYCLES) else $error("write length wrong");
    done_sticky_a: assert property (
        storeDoneFlag && !storeDoneClr |=> storeDoneFlag) else $error("done flag dropped");
    done_clear_a: assert property (
        storeDoneClr && !writeBusy |=> !storeDoneFlag) else $error("done flag not cleared");
    busy_start_a: assert property (
        $rose(writeBusy) |-> $past(regWrEn) && $past(regAddr) == ADDR_CONTROL
            && $past(regWrData[1])) else $error("write started without trigger");
    key_zero_a: assert property (
        regRdEn && regAddr == ADDR_KEY |=> regRdData == READ_ZERO) else $error("key read not 0");
    high_zero_a: assert property (
        regRdEn && regAddr == ADDR_INDEX_HIGH |=> regRdData[7:2] == 6'h00)
        else $error("index high upper bits set");
    bit5_zero_a: assert property (
        ctrlRead |=> !regRdData[5]) else $error("control bit 5 set");
    busy_bit_a: assert property (
        ctrlRead |=> regRdData[1] == $past(writeBusy)) else $error("write bit differs");
    rd_hold_a: assert property (
        !regRdEn |=> $stable(regRdData)) else $error("read data moved");
    abort_stop_a: assert property (
        warmHit |-> ##[1:5] !writeBusy) else $error("write not stopped by reset");
endmodule

bind dee_ctrl dee_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .extResetPin(extResetPin), .watchdogReset(watchdogReset),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .storeDoneClr(storeDoneClr), .storeDoneFlag(storeDoneFlag),
    .writeBusy(writeBusy)
);

// [test/dee_ctrl_tb.sv]
// Self-checking testbench of the data store access controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module dee_ctrl_tb
    import dee_pkg::*;
;
    localparam int unsigned WC = 8;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        extResetPin = 1'b0;
    logic        watchdogReset = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic        regWrEn = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic        regRdEn = 1'b0;
    logic [7:0]  regRdData;
    logic        storeDoneClr = 1'b0;
    logic        storeDoneFlag;
    logic        writeBusy;
    int          fails = 0;
    int          num_checks = 0;

    dee_ctrl #(.WRITE_CYCLES(WC)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .extResetPin(extResetPin),
        .watchdogReset(watchdogReset), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .storeDoneClr(storeDoneClr), .storeDoneFlag(storeDoneFlag), .writeBusy(writeBusy)
    );

    always #25 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [7:0] e, input string n);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        `CHK(n, e, regRdData)
    endtask

    task automatic unlock(input logic [7:0] v);
        wr(ADDR_KEY, KEY_FIRST);
        wr(ADDR_KEY, KEY_SECOND);
        wr(ADDR_CONTROL, v);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdChk(ADDR_CONTROL, 8'h00, "control");
        rdChk(ADDR_KEY, 8'h00, "key");
        rdChk(12'hfb0, 8'h00, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_write;
        int n;
        wr(ADDR_INDEX_HIGH, 8'hff);
        rdChk(ADDR_INDEX_HIGH, 8'h03, "index high");
        wr(ADDR_INDEX_LOW, 8'hff);
        wr(ADDR_BUFFER, 8'h5a);
        wr(ADDR_CONTROL, 8'h04);
        unlock(8'h06);
        `CHK("busy", 1'b1, writeBusy)
        wr(ADDR_BUFFER, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
        rdChk(ADDR_CONTROL, 8'h06, "control busy");
        n = 0;
        while (storeDoneFlag !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("done", 1'b1, storeDoneFlag)
        rdChk(ADDR_CONTROL, 8'h04, "control end");
        rdChk(ADDR_BUFFER, 8'h5a, "buffer kept");
        @(negedge clk_sys);
        storeDoneClr = 1'b1;
        @(negedge clk_sys);
        storeDoneClr = 1'b0;
        `CHK("done clr", 1'b0, storeDoneFlag)
        wr(ADDR_BUFFER, 8'h00);
        wr(ADDR_CONTROL, 8'h05);
        rdChk(ADDR_BUFFER, 8'h5a, "read back");
        rdChk(ADDR_BUFFER, 8'h5a, "read hold");
        $display("test write done");
    endtask

    task automatic t_refuse;
        logic [7:0] v;
        wr(ADDR_CONTROL, 8'h00);
        unlock(8'h06);
        `CHK("busy permit", 1'b0, writeBusy)
        wr(ADDR_KEY, KEY_FIRST);
        wr(ADDR_BUFFER, 8'h11);
        wr(ADDR_KEY, KEY_SECOND);
        wr(ADDR_CONTROL, 8'h06);
        `CHK("busy order", 1'b0, writeBusy)
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'h81 : 8'h41;
            wr(ADDR_CONTROL, v);
            rdChk(ADDR_CONTROL, v & 8'hfe, "select");
            rdChk(ADDR_BUFFER, 8'h11, "select read");
        end
        wr(ADDR_CONTROL, 8'h00);
        $display("test refuse done");
    endtask

    task automatic t_abort;
        logic [7:0] v;
        for (int k = 0; k < 2; k++)
        begin
            v = (k == 0) ? 8'h14 : 8'h94;
            wr(ADDR_INDEX_LOW, 8'h12);
            wr(ADDR_BUFFER, 8'h34);
            wr(ADDR_CONTROL, v);
            unlock(v | 8'h02);
            repeat (2) @(negedge clk_sys);
            if (k == 0)
                extResetPin = 1'b1;
            else
                watchdogReset = 1'b1;
            repeat (3) @(negedge clk_sys);
            extResetPin = 1'b0;
            watchdogReset = 1'b0;
            // Sync delay plus release tail of the warm reset
            repeat (6) @(negedge clk_sys);
            `CHK("busy abort", 1'b0, writeBusy)
            rdChk(ADDR_CONTROL, (v | 8'h08) & 8'hfb, "abort control");
            rdChk(ADDR_INDEX_LOW, 8'h00, "abort index");
            rdChk(ADDR_BUFFER, 8'h00, "abort buffer");
            `CHK("abort done", 1'b0, storeDoneFlag)
        end
        $display("test abort done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_write;
        t_refuse;
        t_abort;
        stop_test;
    end

    initial
    begin
        // All scenarios need about 140 cycles; allow ample margin
        #(50 * 4000);
        fails++;
        stop_test;
    end
endmodule
